// file: core/ufl_defs.svh
`ifndef UFL_DEFS_SVH
`define UFL_DEFS_SVH

// Register byte offsets
`define UFL_OFS_C1 8'h00
`define UFL_OFS_C2 8'h04
`define UFL_OFS_STAT 8'h08

// Reset values
`define UFL_C1_RST 8'h00
`define UFL_C2_RST 8'h00

// Frame options control bit positions
`define UFL_B_LOOP 7
`define UFL_B_FRZ 6
`define UFL_B_RECEIVER_SOURCE_SELECT 5
`define UFL_B_NINE 4
`define UFL_B_WAKE 3
`define UFL_B_QTYPE 2
`define UFL_B_PON 1
`define UFL_B_PODD 0

// Interrupt control bit positions
`define UFL_B_TXE_IE 7
`define UFL_B_TXD_IE 6
`define UFL_B_RXF_IE 5
`define UFL_B_QT_IE 4

// Frame lengths in bit times, also quiet thresholds
`define UFL_LEN_8 4'hA
`define UFL_LEN_9 4'hB

// Only whole-word writes take effect; reads of any size return data
`define UFL_HSIZE_WORD 3'h2

`endif

// file: core/ufl_pkg.sv
package ufl_pkg;

	// Line routing modes
	typedef enum logic [1:0] {
		UFL_M_NORMAL = 2'b00,
		UFL_M_LOOP = 2'b01,
		UFL_M_SINGLE = 2'b10
	} ufl_mode_t;

	// Quiet line counter states
	typedef enum logic [1:0] {
		UFL_Q_HOLD = 2'b00,
		UFL_Q_COUNT = 2'b01,
		UFL_Q_DONE = 2'b10
	} ufl_qstate_t;

endpackage

// file: core/ufl_ahb_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ufl_defs.svh"

module ufl_ahb_regs (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [7:0] status_in,
	output logic [7:0] c1_out,
	output logic [7:0] c2_out
);

	typedef struct packed {
		logic [7:0] c1;
		logic [7:0] c2;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} ufl_rst_t;

	ufl_rst_t st_reg;
	ufl_rst_t st_next;

	// Word index of a mapped offset, 3 when unmapped
	function automatic logic [1:0] sel_of(input logic [7:0] a);
		unique case (a)
			`UFL_OFS_C1: sel_of = 2'h0;
			`UFL_OFS_C2: sel_of = 2'h1;
			`UFL_OFS_STAT: sel_of = 2'h2;
			default: sel_of = 2'h3;
		endcase
	endfunction

	// Write in data phase, then read sees that write
	always_comb begin
		st_next = st_reg;
		st_next.wr_pend = 1'b0;
		if (st_reg.wr_pend) begin
			unique case (sel_of(st_reg.wr_addr))
				2'h0: st_next.c1 = hwdata[7:0];
				2'h1: st_next.c2 = hwdata[7:0];
				default: st_next.c1 = st_next.c1;
			endcase
		end
		if (hsel && hready && htrans[1]) begin
			st_next.wr_pend = hwrite && (hsize == `UFL_HSIZE_WORD);
			st_next.wr_addr = haddr[7:0];
			st_next.rdata = 32'h0000_0000;
			if (!hwrite) begin
				unique case (sel_of(haddr[7:0]))
					2'h0: st_next.rdata = {24'h00_0000, st_next.c1};
					2'h1: st_next.rdata = {24'h00_0000, st_next.c2};
					2'h2: st_next.rdata = {24'h00_0000, status_in};
					default: st_next.rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '{`UFL_C1_RST, `UFL_C2_RST, 1'b0, 8'h00, 32'h0000_0000};
		end else begin
			st_reg <= st_next;
		end
	end

	// Zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_reg.rdata;
	assign c1_out = st_reg.c1;
	assign c2_out = st_reg.c2;

endmodule
`default_nettype wire

// file: core/ufl_quiet_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ufl_defs.svh"

module ufl_quiet_counter (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic bit_tick,
	input wire logic rx_line,
	input wire logic start_seen,
	input wire logic stop_seen,
	input wire logic after_stop,
	input wire logic nine_bit,
	output logic quiet_detect
);

	typedef struct packed {
		ufl_pkg::ufl_qstate_t state;
		logic [3:0] cnt;
		logic det;
	} ufl_qst_t;

	ufl_qst_t st_reg;
	ufl_qst_t st_next;
	logic [3:0] goal;

	assign goal = nine_bit ? `UFL_LEN_9 : `UFL_LEN_8;

	// Count high bit times from start or from stop
	always_comb begin
		st_next = st_reg;
		st_next.det = 1'b0;
		unique case (st_reg.state)
			ufl_pkg::UFL_Q_HOLD: begin
				if (stop_seen || !after_stop) begin
					st_next.state = ufl_pkg::UFL_Q_COUNT;
				end
			end
			ufl_pkg::UFL_Q_COUNT: begin
				if (bit_tick) begin
					st_next.cnt = rx_line ? st_reg.cnt + 4'h1 : 4'h0;
					if (rx_line && (st_reg.cnt + 4'h1 == goal)) begin
						st_next.state = ufl_pkg::UFL_Q_DONE;
						st_next.det = 1'b1;
					end
				end
			end
			ufl_pkg::UFL_Q_DONE: begin
				// Rearm from zero so a stale count cannot wrap past the goal
				if (!rx_line) begin
					st_next.state = ufl_pkg::UFL_Q_COUNT;
					st_next.cnt = 4'h0;
				end
			end
			default: st_next.state = ufl_pkg::UFL_Q_HOLD;
		endcase
		// A new start bit restarts the count
		if (start_seen) begin
			st_next.cnt = 4'h0;
			st_next.state = after_stop ? ufl_pkg::UFL_Q_HOLD : ufl_pkg::UFL_Q_COUNT;
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '{ufl_pkg::UFL_Q_HOLD, 4'h0, 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign quiet_detect = st_reg.det;

endmodule
`default_nettype wire

// file: core/ufl_frame_loop_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "ufl_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module ufl_frame_loop_ctrl (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic tx_out,
	input wire logic tx_enable,
	input wire logic receiver_on,
	input wire logic single_wire_direction,
	input wire logic rxd_pin,
	input wire logic txd_pin_in,
	output logic txd_pin_out,
	output logic txd_pin_oe,
	output logic rx_line,
	output logic rxd_pin_release,
	input wire logic cpu_wait,
	output logic port_clk_run,
	input wire logic tx_load,
	input wire logic [8:0] tx_data,
	output logic [8:0] tx_char,
	output logic tx_char_valid,
	input wire logic rx_char_valid,
	input wire logic [8:0] rx_char,
	output logic rx_parity_err,
	output logic [3:0] frame_len,
	output logic nine_bit,
	output logic wake_addr_mark,
	input wire logic bit_tick,
	input wire logic start_seen,
	input wire logic stop_seen,
	output logic quiet_detect,
	input wire logic tx_buffer_empty_flag,
	input wire logic tx_finished_flag,
	input wire logic rx_buffer_full_flag,
	input wire logic line_quiet_flag,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Types and state

	typedef struct packed {
		ufl_pkg::ufl_mode_t mode;
		logic txd_out;
		logic txd_oe;
		logic rx_line;
		logic rxd_rel;
		logic clk_run;
		logic [8:0] tx_char;
		logic tx_valid;
		logic par_err;
		logic [3:0] frame_len;
		logic irq;
	} ufl_main_t;

	ufl_main_t st_reg;
	ufl_main_t st_next;

	logic [7:0] c1;
	logic [7:0] c2;
	logic [7:0] status;
	logic loop_sel;
	logic receiver_source_select_sel;
	logic parity_on;
	logic parity_odd_select;

	// Xor of the data bits below the parity position
	function automatic logic par_low(input logic [8:0] d, input logic nine);
		par_low = nine ? ^d[7:0] : ^d[6:0];
	endfunction

	// Mode from loop and source bits
	function automatic ufl_pkg::ufl_mode_t mode_of(input logic lp, input logic rs);
		if (!lp) begin
			mode_of = ufl_pkg::UFL_M_NORMAL;
		end else if (!rs) begin
			mode_of = ufl_pkg::UFL_M_LOOP;
		end else begin
			mode_of = ufl_pkg::UFL_M_SINGLE;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	ufl_ahb_regs u_regs (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.status_in(status),
		.c1_out(c1),
		.c2_out(c2)
	);

	// Field split
	assign loop_sel = c1[`UFL_B_LOOP];
	assign receiver_source_select_sel = c1[`UFL_B_RECEIVER_SOURCE_SELECT];
	assign parity_on = c1[`UFL_B_PON];
	assign parity_odd_select = c1[`UFL_B_PODD];
	assign nine_bit = c1[`UFL_B_NINE];
	assign wake_addr_mark = c1[`UFL_B_WAKE];

	// Readback of live state
	assign status = {st_reg.irq, st_reg.clk_run, st_reg.rxd_rel, st_reg.txd_oe,
		st_reg.par_err, 1'b0, st_reg.mode};

	////////////////////////////////////////////////////////////////////////////////
	// Quiet line detection

	ufl_quiet_counter u_quiet (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.bit_tick(bit_tick),
		.rx_line(st_reg.rx_line),
		.start_seen(start_seen),
		.stop_seen(stop_seen),
		.after_stop(c1[`UFL_B_QTYPE]),
		.nine_bit(nine_bit),
		.quiet_detect(quiet_detect)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_next = st_reg;
		st_next.mode = mode_of(loop_sel, receiver_source_select_sel);
		// Pin routing per mode
		st_next.txd_out = tx_out;
		st_next.txd_oe = tx_enable;
		st_next.rxd_rel = loop_sel || !receiver_on;
		unique case (st_next.mode)
			ufl_pkg::UFL_M_NORMAL: begin
				st_next.rx_line = rxd_pin;
			end
			ufl_pkg::UFL_M_LOOP: begin
				st_next.rx_line = tx_out;
			end
			ufl_pkg::UFL_M_SINGLE: begin
				st_next.txd_oe = tx_enable && single_wire_direction;
				st_next.rx_line = single_wire_direction ? tx_out : txd_pin_in;
			end
			default: st_next.rx_line = rxd_pin;
		endcase
		// Wait mode clock gate
		st_next.clk_run = !(cpu_wait && c1[`UFL_B_FRZ]);
		// Frame length in bit times
		st_next.frame_len = nine_bit ? `UFL_LEN_9 : `UFL_LEN_8;
		// Transmit character with parity in msb
		st_next.tx_valid = tx_load;
		if (tx_load) begin
			st_next.tx_char = nine_bit ? tx_data : {1'b0, tx_data[7:0]};
			if (parity_on) begin
				if (nine_bit) begin
					st_next.tx_char[8] = par_low(tx_data, 1'b1) ^ parity_odd_select;
				end else begin
					st_next.tx_char[7] = par_low(tx_data, 1'b0) ^ parity_odd_select;
				end
			end
		end
		// Receive parity check, pulse per character
		st_next.par_err = 1'b0;
		if (rx_char_valid && parity_on) begin
			st_next.par_err = (par_low(rx_char, nine_bit)
				^ (nine_bit ? rx_char[8] : rx_char[7])) != parity_odd_select;
		end
		// Combined interrupt request
		st_next.irq = (tx_buffer_empty_flag && c2[`UFL_B_TXE_IE])
			|| (tx_finished_flag && c2[`UFL_B_TXD_IE])
			|| (rx_buffer_full_flag && c2[`UFL_B_RXF_IE])
			|| (line_quiet_flag && c2[`UFL_B_QT_IE]);
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '{ufl_pkg::UFL_M_NORMAL, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1,
				9'h000, 1'b0, 1'b0, `UFL_LEN_8, 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign txd_pin_out = st_reg.txd_out;
	assign txd_pin_oe = st_reg.txd_oe;
	assign rx_line = st_reg.rx_line;
	assign rxd_pin_release = st_reg.rxd_rel;
	assign port_clk_run = st_reg.clk_run;
	assign tx_char = st_reg.tx_char;
	assign tx_char_valid = st_reg.tx_valid;
	assign rx_parity_err = st_reg.par_err;
	assign frame_len = st_reg.frame_len;
	assign irq = st_reg.irq;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	property p_normal_rx;
		!loop_sel |=> rx_line == $past(rxd_pin);
	endproperty
	a_normal_rx: assert property (p_normal_rx) else $error("normal rx path wrong");

	property p_loop_rx;
		loop_sel && !receiver_source_select_sel |=> rx_line == $past(tx_out) && rxd_pin_release;
	endproperty
	a_loop_rx: assert property (p_loop_rx) else $error("loopback path wrong");

	property p_receiver_source_select_ignored;
		!loop_sel |=> txd_pin_oe == $past(tx_enable);
	endproperty
	a_receiver_source_select_ignored: assert property (p_receiver_source_select_ignored) else $error("source bit leaks");

	property p_single;
		loop_sel && receiver_source_select_sel && !single_wire_direction
			|=> !txd_pin_oe && rx_line == $past(txd_pin_in);
	endproperty
	a_single: assert property (p_single) else $error("single wire input wrong");

	property p_single_drive;
		loop_sel && receiver_source_select_sel && single_wire_direction && tx_enable
			|=> txd_pin_oe && rx_line == txd_pin_out;
	endproperty
	a_single_drive: assert property (p_single_drive) else $error("single wire drive wrong");

	property p_release;
		loop_sel |=> rxd_pin_release;
	endproperty
	a_release: assert property (p_release) else $error("input pin not released");

	property p_freeze;
		cpu_wait && c1[`UFL_B_FRZ] |=> !port_clk_run;
	endproperty
	a_freeze: assert property (p_freeze) else $error("wait clock gate wrong");

	property p_frame_len;
		##1 frame_len == ($past(nine_bit) ? 4'hB : 4'hA);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

	property p_parity;
		tx_load && parity_on |=> (^tx_char) == $past(parity_odd_select);
	endproperty
	a_parity: assert property (p_parity) else $error("tx parity wrong");

	property p_irq;
		rx_buffer_full_flag && c2[`UFL_B_RXF_IE] ##1 1'b1 |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("rx full irq missing");

	property p_irq_quiet;
		!((tx_buffer_empty_flag && c2[`UFL_B_TXE_IE]) || (tx_finished_flag && c2[`UFL_B_TXD_IE])
			|| (rx_buffer_full_flag && c2[`UFL_B_RXF_IE]) || (line_quiet_flag && c2[`UFL_B_QT_IE]))
			|=> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq without source");

	property p_clk_run;
		!(cpu_wait && c1[`UFL_B_FRZ]) |=> port_clk_run;
	endproperty
	a_clk_run: assert property (p_clk_run) else $error("port clocks stopped");

	property p_eight_top;
		tx_load && !nine_bit |=> !tx_char[8];
	endproperty
	a_eight_top: assert property (p_eight_top) else $error("eight bit char has bit 8");

	property p_nine_plain;
		tx_load && nine_bit && !parity_on |=> tx_char == $past(tx_data);
	endproperty
	a_nine_plain: assert property (p_nine_plain) else $error("char altered without parity");

	property p_par_nine;
		tx_load && nine_bit && parity_on |=> (tx_char & 9'h0FF) == ($past(tx_data) & 9'h0FF);
	endproperty
	a_par_nine: assert property (p_par_nine) else $error("data bits under parity altered");

	property p_rx_par_off;
		!parity_on |=> !rx_parity_err;
	endproperty
	a_rx_par_off: assert property (p_rx_par_off) else $error("parity error while off");

	property p_irq_txe;
		tx_buffer_empty_flag && c2[`UFL_B_TXE_IE] |=> irq;
	endproperty
	a_irq_txe: assert property (p_irq_txe) else $error("tx empty irq missing");

	property p_irq_txd;
		tx_finished_flag && c2[`UFL_B_TXD_IE] |=> irq;
	endproperty
	a_irq_txd: assert property (p_irq_txd) else $error("tx done irq missing");

	property p_irq_qt;
		line_quiet_flag && c2[`UFL_B_QT_IE] |=> irq;
	endproperty
	a_irq_qt: assert property (p_irq_qt) else $error("line quiet irq missing");

endmodule
`default_nettype wire

// file: tb/ufl_remote_dev.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Far-end serial device: own output line, optional drive of the shared line
module ufl_remote_dev (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic want_level,
	input wire logic want_drive,
	input wire logic shared_line,
	output logic rxd_out,
	output logic line_oe,
	output logic line_out,
	output logic heard
);
	// Idle high out of reset, shared line released until asked to drive
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxd_out <= 1'b1;
			line_oe <= 1'b0;
			line_out <= 1'b1;
			heard <= 1'b1;
		end else begin
			rxd_out <= want_level;
			line_oe <= want_drive;
			line_out <= want_level;
			heard <= shared_line;
		end
	end
endmodule
`default_nettype wire

// file: tb/tb_uart_frame_and_loop_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "ufl_defs.svh"

module tb_uart_frame_and_loop_control;
	logic core_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = `UFL_HSIZE_WORD;
	logic hreadyout, hresp, tx_out = 1'b1, tx_enable = 1'b1, receiver_on = 1'b1;
	logic single_wire_direction = 1'b0, rxd_pin, txd_pin_in, txd_pin_out, txd_pin_oe;
	logic rx_line, rxd_pin_release, cpu_wait = 1'b0, port_clk_run, tx_load = 1'b0;
	logic [8:0] tx_data = 9'h0, tx_char, rx_char = 9'h0, d;
	logic tx_char_valid, rx_char_valid = 1'b0, rx_parity_err, nine_bit, wake_addr_mark;
	logic [3:0] frame_len, fl = 4'h0;
	logic bit_tick = 1'b0, start_seen = 1'b0, stop_seen = 1'b0, quiet_detect, irq;
	logic want_level = 1'b1, want_drive = 1'b0, line_oe, line_out, heard;
	logic [2:0] m;
	int n_mismatch = 0, samples_checked = 0, q_cnt = 0, q0;

	// Clock, shared line with pull-up, quiet pulse counter
	always #12.5 core_clk = ~core_clk;
	assign txd_pin_in = txd_pin_oe ? txd_pin_out : (line_oe ? line_out : 1'b1);
	always @(posedge core_clk) if (quiet_detect === 1'b1) q_cnt++;

	ufl_frame_loop_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx_out(tx_out),
		.tx_enable(tx_enable), .receiver_on(receiver_on),
		.single_wire_direction(single_wire_direction), .rxd_pin(rxd_pin),
		.txd_pin_in(txd_pin_in), .txd_pin_out(txd_pin_out), .txd_pin_oe(txd_pin_oe),
		.rx_line(rx_line), .rxd_pin_release(rxd_pin_release), .cpu_wait(cpu_wait),
		.port_clk_run(port_clk_run), .tx_load(tx_load), .tx_data(tx_data), .tx_char(tx_char),
		.tx_char_valid(tx_char_valid), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
		.rx_parity_err(rx_parity_err), .frame_len(frame_len), .nine_bit(nine_bit),
		.wake_addr_mark(wake_addr_mark), .bit_tick(bit_tick), .start_seen(start_seen),
		.stop_seen(stop_seen), .quiet_detect(quiet_detect), .tx_buffer_empty_flag(fl[3]),
		.tx_finished_flag(fl[2]), .rx_buffer_full_flag(fl[1]), .line_quiet_flag(fl[0]),
		.irq(irq));
	ufl_remote_dev i_far (.core_clk(core_clk), .rst_b(rst_b), .want_level(want_level),
		.want_drive(want_drive), .shared_line(txd_pin_in), .rxd_out(rxd_pin),
		.line_oe(line_oe), .line_out(line_out), .heard(heard));

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and compare helpers
	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	task settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Bounded wait for hready at a rising edge
	task wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			test_done;
		end
	endtask

	// One single word transfer, read data kept in rd
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
	endtask

	task pin(input logic t, input logic r, input logic s, input logic w);
		@(posedge core_clk);
		tx_out <= t;
		want_level <= r;
		single_wire_direction <= s;
		want_drive <= w;
		settle(3);
	endtask

	task tick(input int n);
		repeat (n) begin
			@(posedge core_clk);
			bit_tick <= 1'b1;
			@(posedge core_clk);
			bit_tick <= 1'b0;
		end
	endtask

	task mark(input logic stop);
		@(posedge core_clk);
		if (stop) stop_seen <= 1'b1;
		else start_seen <= 1'b1;
		@(posedge core_clk);
		stop_seen <= 1'b0;
		start_seen <= 1'b0;
	endtask

	// Character with parity placed in its top data bit
	function automatic logic [8:0] exp_tx(input logic [8:0] v, input logic [2:0] c);
		logic [8:0] r;
		r = c[2] ? v : {1'b0, v[7:0]};
		if (c[1] && c[2]) r[8] = ^v[7:0] ^ c[0];
		if (c[1] && !c[2]) r[7] = ^v[6:0] ^ c[0];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		ahb(1'b0, `UFL_OFS_C1, 32'h0);
		chk(rd, {24'h0, `UFL_C1_RST});
		ahb(1'b0, `UFL_OFS_C2, 32'h0);
		chk(rd, {24'h0, `UFL_C2_RST});
		ahb(1'b1, `UFL_OFS_C2, 32'hFFFF_FFA5);
		ahb(1'b0, `UFL_OFS_C2, 32'h0);
		chk(rd, 32'hA5);
		ahb(1'b1, 8'h0C, 32'h5A);
		ahb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		chk(hresp, 1'b0);
		// Normal, loopback and single-wire routing
		ahb(1'b1, `UFL_OFS_C1, 32'h20);
		pin(1'b0, 1'b0, 1'b0, 1'b0);
		chk(rx_line, 1'b0);
		chk(txd_pin_out, 1'b0);
		chk(rxd_pin_release, 1'b0);
		pin(1'b0, 1'b1, 1'b0, 1'b0);
		chk(rx_line, 1'b1);
		ahb(1'b1, `UFL_OFS_C1, 32'h80);
		pin(1'b0, 1'b1, 1'b0, 1'b0);
		chk(rx_line, 1'b0);
		chk(rxd_pin_release, 1'b1);
		pin(1'b1, 1'b0, 1'b0, 1'b0);
		chk(rx_line, 1'b1);
		ahb(1'b1, `UFL_OFS_C1, 32'hA0);
		pin(1'b1, 1'b0, 1'b0, 1'b1);
		chk(txd_pin_oe, 1'b0);
		chk(rx_line, 1'b0);
		pin(1'b0, 1'b1, 1'b1, 1'b0);
		chk(txd_pin_oe, 1'b1);
		chk(heard, 1'b0);
		chk(rx_line, 1'b0);
		pin(1'b1, 1'b0, 1'b1, 1'b0);
		chk(heard, 1'b1);
		chk(rx_line, 1'b1);
		ahb(1'b0, `UFL_OFS_STAT, 32'h0);
		chk(rd[1:0], 2'h2);
		// Clocks in wait, wakeup method
		ahb(1'b1, `UFL_OFS_C1, 32'h08);
		@(posedge core_clk);
		cpu_wait <= 1'b1;
		settle(2);
		chk(port_clk_run, 1'b1);
		chk(wake_addr_mark, 1'b1);
		ahb(1'b1, `UFL_OFS_C1, 32'h40);
		settle(2);
		chk(port_clk_run, 1'b0);
		chk(wake_addr_mark, 1'b0);
		// Every length and parity setting, transmit and receive
		for (int k = 0; k < 8; k++) begin
			m = k[2:0];
			d = 9'h1B5 ^ 9'(k * 37);
			ahb(1'b1, `UFL_OFS_C1, {27'h0, m[2], 2'h0, m[1:0]});
			settle(2);
			chk(frame_len, m[2] ? `UFL_LEN_9 : `UFL_LEN_8);
			chk(nine_bit, m[2]);
			@(posedge core_clk);
			tx_load <= 1'b1;
			tx_data <= d;
			rx_char_valid <= 1'b1;
			rx_char <= d;
			@(posedge core_clk);
			tx_load <= 1'b0;
			rx_char_valid <= 1'b0;
			#1;
			chk(tx_char_valid, 1'b1);
			chk(tx_char, exp_tx(d, m));
			chk(rx_parity_err, m[1] && ((m[2] ? ^d : ^d[7:0]) != m[0]));
			settle(1);
			chk(tx_char_valid, 1'b0);
		end
		// Quiet line counting from start bit, then from stop bit
		ahb(1'b1, `UFL_OFS_C1, 32'h0);
		for (int t = 0; t < 2; t++) begin
			pin(1'b1, 1'b0, 1'b0, 1'b0);
			tick(1);
			mark(1'b0);
			pin(1'b1, 1'b1, 1'b0, 1'b0);
			q0 = q_cnt;
			tick(t == 0 ? 9 : 12);
			settle(3);
			chk(q_cnt - q0, 0);
			if (t == 1) mark(1'b1);
			tick(t == 0 ? 1 : 10);
			settle(3);
			chk(q_cnt - q0, 1);
			ahb(1'b1, `UFL_OFS_C1, 32'h04);
		end
		// Each interrupt source alone, then all enabled together
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, `UFL_OFS_C2, 32'h10 << i);
			@(posedge core_clk);
			fl <= ~(4'h1 << i);
			settle(2);
			chk(irq, 1'b0);
			@(posedge core_clk);
			fl <= 4'h1 << i;
			settle(2);
			chk(irq, 1'b1);
		end
		ahb(1'b1, `UFL_OFS_C2, 32'hF0);
		@(posedge core_clk);
		fl <= 4'h2;
		settle(2);
		chk(irq, 1'b1);
		@(posedge core_clk);
		fl <= 4'h0;
		settle(2);
		chk(irq, 1'b0);
		test_done;
	end

	// Run guard
	initial begin
		#500000;
		n_mismatch++;
		test_done;
	end
endmodule
`default_nettype wire
